// File: test_tsc_regs.sv
// Self-checking bench for tsc_regs: registers over the two-wire port,
// pass timing, one-shot and resets. Assumes tsc_bm as bus master.
`timescale 1ns/10ps
module test_tsc_regs;
   localparam TK = 20; // Short eighth-second tick
   localparam [6:0] SA = 7'h4c; // Slave address
   localparam [7:0] MK = 8'h5a; // Arbitrary value
   localparam [7:0] PT = 8'hc3; // Arbitrary value
   // Cases {enables, 0, rate code}
   localparam [103:0] RT = 104'hf0_f1_f2_f3_f4_f5_f6_f7_76_77_36_37_17;
   reg clock = 1'b0;
   reg sys_rst = 1'b1;
   reg meas_done = 1'b0;
   wire scl, m_low, sda_out, sda_oe, meas_start, conv_busy, range_ext, res_corr;
   wire [1:0] meas_chan;
   wire [8:0] ideality_denom;
   wire sda = ~(m_low | sda_oe); // Pulled-up wire
   integer num_errors = 0;
   integer tests_run = 0;
   integer cyc = 0; // Cycle count
   integer fe_cnt = 0; // Front-end countdown
   integer fe_long = 0; // Slow front end
   integer ns = 0; // Starts seen
   integer t0, t1, i, k;
   reg [31:0] seed = 32'h88e2be96;
   reg [3:0] en = 4'hf; // Enabled channels
   reg [7:0] adj [1:3]; // Expected adjusts
   reg [7:0] d;
   reg [1:0] last = 2'd0;
   reg busy_q = 1'b0;
   reg ack;
   tsc_bm tsc_bm_i (.scl(scl), .sda_low(m_low), .sda(sda));
   tsc_regs #(.SLAVE_ADDR(SA), .MAKER_ID(MK), .PART_ID(PT), .TICK_CYCLES(TK)) tsc_regs_i (
      .clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .meas_done(meas_done), .meas_start(meas_start), .meas_chan(meas_chan), .conv_busy(conv_busy),
      .ideality_denom(ideality_denom), .range_ext(range_ext), .res_corr(res_corr));
   initial begin
      forever #2.5 clock = ~clock;
   end
   function [7:0] rnd();
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         rnd = seed[7:0];
      end
   endfunction
   // First enabled channel from c on, 4 if none
   function integer nxt(input [3:0] e, input integer c);
      integer j;
      begin
         nxt = 4;
         for (j = 3; j >= c; j = j - 1)
            if (e[j]) nxt = j;
      end
   endfunction
   // Pass period in cycles; slow codes win over channel count
   function integer per(input [2:0] c, input [3:0] e);
      integer s;
      begin
         s = 128 >> c;
         per = (s > $countones(e) ? s : $countones(e)) * TK;
      end
   endfunction
   task check(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task summarize;
      begin
         $display("checks %0d errors %0d", tests_run, num_errors);
         if (num_errors == 0 && tests_run > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   // Front end: answers each start after a random countdown of 1 to 8, or a fixed 400 when fe_long is set
   always @(posedge clock) begin
      cyc <= cyc + 1;
      busy_q <= conv_busy;
      meas_done <= 1'b0;
      ns <= ns + meas_start;
      if (meas_start) begin
         check(meas_chan, nxt(en, busy_q ? last + 1 : 0));
         last <= meas_chan;
         fe_cnt <= fe_long ? 400 : 1 + rnd() % 8;
      end else if (fe_cnt == 1) begin
         check(ideality_denom, 300 - (meas_chan ? $signed(adj[meas_chan]) : 0));
         meas_done <= 1'b1;
         fe_cnt <= 0;
      end else if (fe_cnt > 1) begin
         fe_cnt <= fe_cnt - 1;
      end
   end
   // Hang guard
   always @(posedge clock) if (cyc == 100000) begin
      num_errors = num_errors + 1;
      summarize;
   end
   // Address byte, expecting an answer
   task adr(input rw);
      begin
         tsc_bm_i.start;
         tsc_bm_i.put({SA, rw}, ack);
         check(ack, 1);
      end
   endtask
   // Offset 1 ns keeps bus edges off clock edges
   task wr(input [7:0] p, input [7:0] v);
      begin
         @(posedge clock) #1;
         adr(1'b0);
         tsc_bm_i.put(p, ack);
         check(ack, 1);
         tsc_bm_i.put(v, ack);
         check(ack, 1);
         tsc_bm_i.stop;
      end
   endtask
   // Pointer write, repeated start, one byte back
   task rd(input [7:0] p, input [7:0] e);
      begin
         @(posedge clock) #1;
         adr(1'b0);
         tsc_bm_i.put(p, ack);
         adr(1'b1);
         tsc_bm_i.get(1'b1, d);
         tsc_bm_i.stop;
         check(d, e);
      end
   endtask
   // General call and its command byte
   task gc(input [7:0] v);
      begin
         @(posedge clock) #1;
         tsc_bm_i.start;
         tsc_bm_i.put(8'h00, ack);
         check(ack, 1);
         tsc_bm_i.put(v, ack);
         tsc_bm_i.stop;
      end
   endtask
   // Bounded wait for the end of a pass
   task idle;
      begin
         k = 0;
         while (conv_busy !== 1'b0 && k < 3000) begin
            @(posedge clock);
            k = k + 1;
         end
      end
   endtask
   // Shutdown on waits out the running pass
   task sd(input s);
      begin
         wr(8'h09, {1'b0, s, 6'h00});
         if (s) idle;
      end
   endtask
   // Cycle of the next pass start
   task rise(output integer t);
      begin
         k = 0;
         while (!(conv_busy === 1'b1 && busy_q === 1'b0) && k < 6000) begin
            @(posedge clock) #1;
            k = k + 1;
         end
         t = cyc;
         @(posedge clock) #1;
      end
   endtask
   initial begin
      for (i = 1; i <= 3; i = i + 1) adj[i] = 8'h00;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clock);
      rd(8'h0b, 8'h07);
      rd(8'hfe, MK);
      // Read-only and unmapped writes are dropped
      wr(8'hff, 8'h00);
      wr(8'h40, 8'h11);
      rd(8'hff, PT);
      sd(1'b1); // No pass may see an adjust change mid-check
      // Adjusts: reset value, both extremes, a random one
      for (i = 1; i <= 3; i = i + 1) begin
         rd(8'h20 + i[7:0], 8'h00);
         d = (i == 1) ? 8'h7f : (i == 2) ? 8'h80 : rnd();
         wr(8'h20 + i[7:0], d);
         adj[i] = d;
         rd(8'h20 + i[7:0], adj[i]);
      end
      // Foreign address gets no answer
      @(posedge clock) #1;
      tsc_bm_i.start;
      tsc_bm_i.put({SA ^ 7'h01, 1'b0}, ack);
      check(ack, 0);
      tsc_bm_i.stop;
      // Pass period per rate code and channel count
      for (i = 0; i < 13; i = i + 1) begin
         d = RT[8*i +: 8];
         if (d[7:4] != en) begin
            sd(1'b1);
            wr(8'h0a, {1'b0, d[7:4], 3'b100});
            en = d[7:4];
            wr(8'h0b, {5'h00, d[2:0]});
            sd(1'b0);
         end else begin
            wr(8'h0b, {5'h00, d[2:0]});
         end
         rise(t0);
         rise(t1);
         check(t1 - t0 >= per(d[2:0], en) && t1 - t0 <= per(d[2:0], en) + 1, 1);
      end
      // One-shot from idle shutdown; a second while busy is dropped
      wr(8'h0b, 8'h07);
      sd(1'b1);
      fe_long = 1;
      t0 = ns;
      wr(8'h0f, rnd());
      wr(8'h0f, 8'h00);
      idle;
      repeat (600) @(posedge clock);
      check(ns - t0, 4);
      check(conv_busy, 0);
      rd(8'h08, 8'h00);
      rd(8'h0f, 8'h00);
      // Soft reset by its trigger address
      wr(8'h0b, 8'h03);
      for (i = 1; i <= 3; i = i + 1) adj[i] = 8'h00;
      wr(8'hfc, rnd());
      rd(8'h0b, 8'h07);
      rd(8'h21, 8'h00);
      // General call: other byte ignored, reset code obeyed
      sd(1'b1);
      wr(8'h0b, 8'h03);
      wr(8'h22, 8'h11);
      adj[2] = 8'h11;
      gc(8'h05);
      rd(8'h0b, 8'h03);
      rd(8'h22, 8'h11);
      adj[2] = 8'h00;
      gc(8'h06);
      rd(8'h0b, 8'h07);
      rd(8'h22, 8'h00);
      summarize;
   end
endmodule

// File: tsc_bm.sv
// Two-wire bus master model: makes the link clock and START/STOP.
// Assumes a pull-up on the data wire outside this module.
`timescale 1ns/10ps
module tsc_bm (
   output reg scl,
   output reg sda_low,
   input wire sda
);
   localparam real Q = 31.25; // Quarter of a 125 ns bit
   reg r;
   integer i;
   // Idle bus, clock stands high between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // One bit: data moves while clock low
   task bit_io(input b, output v);
      begin
         sda_low = ~b;
         #Q scl = 1'b1;
         #Q v = sda;
         #Q scl = 1'b0;
         #Q;
      end
   endtask
   // Data falls with clock high; also a repeated start
   task start;
      begin
         sda_low = 1'b0;
         #Q scl = 1'b1;
         #Q sda_low = 1'b1;
         #Q scl = 1'b0;
         #Q;
      end
   endtask
   // Data rises with clock high
   task stop;
      begin
         sda_low = 1'b1;
         #Q scl = 1'b1;
         #Q sda_low = 1'b0;
         #Q;
      end
   endtask
   // Byte out, top bit first, then the slave's answer
   task put(input [7:0] d, output ack);
      begin
         for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
         bit_io(1'b1, r);
         ack = ~r;
      end
   endtask
   // Byte in; last byte left unacknowledged
   task get(input last, output [7:0] d);
      begin
         for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, d[i]);
         bit_io(last, r);
      end
   endtask
endmodule

// File: tsc_consts.vh
// Constants for the temperature sensor control block: pointer offsets,
// reset values, field positions and timing counts.
// Assumes a 200 MHz system clock; included by the top and sequencer design files.
// Overview of operation
// [RULE_01] Rate register, power-on 07h, eight rate codes
// [RULE_02] Rate code 6 slows with three/four channels
// [RULE_03] Rate code 7 slows with two+ channels
// [RULE_04] One-shot write in shutdown starts one pass
// [RULE_05] After one-shot pass, stay in shutdown
// [RULE_06] One-shot data byte is discarded
// [RULE_07] One-shot during a running pass is ignored
// [RULE_08] Three signed ideality adjust registers, read/write
// [RULE_09] Ideality adjust registers reset to 00h
// [RULE_10] Effective ideality uses 300 minus adjustment
// [RULE_11] Soft reset write restores registers, aborts conversion
// [RULE_12] General call then 06h gives soft reset
// [RULE_13] Other general call bytes do nothing
// [RULE_14] Read-only maker and part code registers
// [RULE_15] Master drives clock, START, STOP; we're slave
// [RULE_16] Seven address bits, direction, ack on ninth
// [RULE_17] Eight-bit bytes plus ack; SDA stable high
// [RULE_18] START and STOP are SDA edges, SCL high
// [RULE_19] Bytes travel most significant bit first
// [RULE_20] Works from 1 kHz up to 3.4 MHz
// [RULE_21] Fixed channel order, then delay, then repeat
// [RULE_22] Enable bits skip disabled channels
// [RULE_23] First write byte loads pointer; reads use it
// [RULE_24] Idle delay from rate code; reset restarts sequence
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH

// Pointer offsets
`define TSC_PTR_STATUS 8'h08
`define TSC_PTR_CFG1 8'h09
`define TSC_PTR_CFG2 8'h0a
`define TSC_PTR_RATE 8'h0b
`define TSC_PTR_ONESHOT 8'h0f
`define TSC_PTR_ADJ1 8'h21
`define TSC_PTR_ADJ2 8'h22
`define TSC_PTR_ADJ3 8'h23
`define TSC_PTR_SWRST 8'hfc
`define TSC_PTR_MAKER 8'hfe
`define TSC_PTR_PART 8'hff

// Reset values
`define TSC_RATE_RST 8'h07
`define TSC_CFG1_RST 8'h00
`define TSC_CFG2_RST 8'h7c
`define TSC_ADJ_RST 8'h00

// Field positions and masks
`define TSC_CFG1_SD 6
`define TSC_CFG1_MASK 8'h44
`define TSC_CFG2_MASK 8'h7c
`define TSC_CFG2_RC 2
`define TSC_CFG2_EN_LO 3
`define TSC_CFG1_RANGE 2

// Bus constants
`define TSC_GCALL_ADDR 7'h00
`define TSC_GCALL_RESET 8'h06

// Ideality arithmetic base
`define TSC_IDEAL_BASE 9'h12c

// Rate timing: base tick is one eighth of a second
`define TSC_TICK_MS 125
`define TSC_CLK_KHZ 200000
`define TSC_TICK_CYCLES (`TSC_TICK_MS * `TSC_CLK_KHZ)
`define TSC_SLOWEST_EIGHTHS 8'h80

`endif

// File: tsc_regs.v
// Top of the temperature sensor control block: two-wire slave port,
// pointer-addressed register bank and conversion sequencer.
// Assumes SCL and SDA arrive asynchronously from an external master,
// and the front end answers each meas_start with one meas_done pulse.
`timescale 1ns/10ps
`include "tsc_consts.vh"
module tsc_regs #(
   parameter SLAVE_ADDR = 7'h4c,
   parameter MAKER_ID = 8'ha5, // Arbitrary value
   parameter PART_ID = 8'h3c, // Arbitrary value
   parameter TICK_CYCLES = `TSC_TICK_CYCLES,
   parameter TICK_W = 25
) (
   input wire clock,
   input wire sys_rst,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   input wire meas_done,
   output wire meas_start,
   output wire [1:0] meas_chan,
   output wire conv_busy,
   output reg [8:0] ideality_denom,
   output reg range_ext,
   output reg res_corr
);

   localparam ST_IDLE = 2'h0;
   localparam ST_ADDR = 2'h1;
   localparam ST_WRITE = 2'h2;
   localparam ST_READ = 2'h3;

   wire scl_s; // Synchronised clock line
   wire sda_s; // Synchronised data line
   reg scl_d; // Previous clock sample
   reg sda_d; // Previous data sample
   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;

   reg [1:0] state; // Slave port state
   reg [3:0] bitcnt; // 0..8 bits, 9 is the ack slot
   reg [7:0] shift_in; // Received byte
   reg [7:0] tx; // Byte being sent
   reg mack; // Ack seen in last ack slot
   reg gcall; // Transfer is a general call
   reg ptr_done; // Pointer loaded in this write
   reg soft_rst; // One-cycle soft reset pulse
   reg one_shot; // One-cycle one-shot pulse
   wire rst; // System or soft reset

   reg [7:0] pointer; // Register pointer
   reg [7:0] cfg1; // Shutdown and range
   reg [7:0] cfg2; // Channel enables and correction
   reg [7:0] rate_reg; // Conversion rate
   reg [7:0] adj [1:3]; // Ideality adjustments by remote channel
   reg [7:0] rd_data; // Read mux
   reg [9:0] denom_calc; // 300 minus signed adjustment
   reg [7:0] adj_sel; // Adjustment of the channel in progress

   assign rst = sys_rst | soft_rst; // RULE_11

   // Pins are outside our domain: two flops each
   tsc_sync #(
      .WIDTH(1)
   ) u_sync_scl (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in(scl_in),
      .sync_out(scl_s)
   );

   tsc_sync #(
      .WIDTH(1)
   ) u_sync_sda (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in(sda_in),
      .sync_out(sda_s)
   );

   // Edge history of the synchronised lines
   always @(posedge clock) begin
      if (sys_rst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign bus_start = scl_s & scl_d & sda_d & ~sda_s; // RULE_18
   assign bus_stop = scl_s & scl_d & ~sda_d & sda_s; // RULE_18

   // Read data by pointer; reserved and unmapped read zero
   always @* begin
      if (pointer == `TSC_PTR_STATUS)
         rd_data = {conv_busy, 7'h00};
      else if (pointer == `TSC_PTR_CFG1)
         rd_data = cfg1;
      else if (pointer == `TSC_PTR_CFG2)
         rd_data = cfg2;
      else if (pointer == `TSC_PTR_RATE)
         rd_data = rate_reg; // RULE_01
      else if (pointer == `TSC_PTR_ADJ1)
         rd_data = adj[1]; // RULE_08
      else if (pointer == `TSC_PTR_ADJ2)
         rd_data = adj[2];
      else if (pointer == `TSC_PTR_ADJ3)
         rd_data = adj[3];
      else if (pointer == `TSC_PTR_MAKER)
         rd_data = MAKER_ID; // RULE_14
      else if (pointer == `TSC_PTR_PART)
         rd_data = PART_ID; // RULE_14
      else
         rd_data = 8'h00;
   end

   // Slave port; only the master clocks the bus, we follow its edges
   always @(posedge clock) begin // RULE_15 RULE_20
      if (sys_rst) begin
         state <= ST_IDLE;
         bitcnt <= 4'h0;
         shift_in <= 8'h00;
         tx <= 8'h00;
         mack <= 1'b0;
         gcall <= 1'b0;
         ptr_done <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end else if (bus_start) begin
         // Repeated START is legal anywhere
         state <= ST_ADDR;
         bitcnt <= 4'h0;
         gcall <= 1'b0;
         ptr_done <= 1'b0;
         sda_oe <= 1'b0;
      end else if (bus_stop) begin
         state <= ST_IDLE;
         sda_oe <= 1'b0;
      end else if (scl_rise && state != ST_IDLE) begin
         // Sample on the rising clock edge
         if (bitcnt < 4'h8) begin
            bitcnt <= bitcnt + 4'h1;
            if (state != ST_READ)
               shift_in <= {shift_in[6:0], sda_s}; // RULE_19
         end else if (bitcnt == 4'h9) begin
            mack <= ~sda_s; // Our own ack also reads low here
         end
      end else if (scl_fall && state != ST_IDLE) begin
         // Change SDA only while the clock is low
         if (bitcnt == 4'h8) begin
            bitcnt <= 4'h9;
            sda_oe <= 1'b0;
            if (state == ST_ADDR) begin
               if (shift_in[7:1] == SLAVE_ADDR) begin
                  sda_oe <= 1'b1; // RULE_16
                  state <= shift_in[0] ? ST_READ : ST_WRITE;
                  tx <= rd_data; // RULE_23
               end else if (shift_in[7:1] == `TSC_GCALL_ADDR && !shift_in[0]) begin
                  sda_oe <= 1'b1; // RULE_12
                  gcall <= 1'b1;
                  state <= ST_WRITE;
               end else begin
                  state <= ST_IDLE;
               end
            end else if (state == ST_WRITE) begin
               sda_oe <= 1'b1; // RULE_17
               if (!gcall && !ptr_done)
                  ptr_done <= 1'b1;
            end
         end else if (bitcnt == 4'h9) begin
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
            if (state == ST_READ) begin
               if (mack) begin
                  sda_oe <= ~tx[7]; // RULE_19
                  tx <= {tx[6:0], 1'b0};
               end else begin
                  state <= ST_IDLE; // Master declined more data
               end
            end
         end else if (state == ST_READ && bitcnt != 4'h0) begin
            sda_oe <= ~tx[7]; // RULE_17
            tx <= {tx[6:0], 1'b0};
         end
      end
   end

   // Register writes land as the write byte is acknowledged
   always @(posedge clock) begin
      if (rst) begin
         pointer <= 8'h00;
         cfg1 <= `TSC_CFG1_RST;
         cfg2 <= `TSC_CFG2_RST;
         rate_reg <= `TSC_RATE_RST; // RULE_01
         adj[1] <= `TSC_ADJ_RST; // RULE_09
         adj[2] <= `TSC_ADJ_RST;
         adj[3] <= `TSC_ADJ_RST;
         soft_rst <= 1'b0;
         one_shot <= 1'b0;
      end else begin
         soft_rst <= 1'b0;
         one_shot <= 1'b0;
         if (scl_fall && !bus_start && !bus_stop && state == ST_WRITE && bitcnt == 4'h8) begin
            if (gcall) begin
               if (shift_in == `TSC_GCALL_RESET) // RULE_13
                  soft_rst <= 1'b1; // RULE_12
               // Other codes fall through untouched
            end else if (!ptr_done) begin
               pointer <= shift_in; // RULE_23
            end else if (pointer == `TSC_PTR_CFG1) begin
               cfg1 <= shift_in & `TSC_CFG1_MASK;
            end else if (pointer == `TSC_PTR_CFG2) begin
               cfg2 <= shift_in & `TSC_CFG2_MASK; // RULE_22
            end else if (pointer == `TSC_PTR_RATE) begin
               rate_reg <= shift_in; // RULE_01
            end else if (pointer == `TSC_PTR_ADJ1) begin
               adj[1] <= shift_in; // RULE_08
            end else if (pointer == `TSC_PTR_ADJ2) begin
               adj[2] <= shift_in;
            end else if (pointer == `TSC_PTR_ADJ3) begin
               adj[3] <= shift_in;
            end else if (pointer == `TSC_PTR_ONESHOT) begin
               one_shot <= 1'b1; // RULE_04 RULE_06
            end else if (pointer == `TSC_PTR_SWRST) begin
               soft_rst <= 1'b1; // RULE_11
            end
         end
      end
   end

   // Denominator for the remote ideality: base minus signed adjustment
   always @* begin
      adj_sel = 8'h00;
      if (meas_chan != 2'h0)
         adj_sel = adj[meas_chan];
      denom_calc = `TSC_IDEAL_BASE - {{2{adj_sel[7]}}, adj_sel}; // RULE_10
   end

   // Front-end controls held in flops
   always @(posedge clock) begin
      if (rst) begin
         ideality_denom <= `TSC_IDEAL_BASE;
         range_ext <= 1'b0;
         res_corr <= 1'b1;
      end else begin
         ideality_denom <= denom_calc[8:0]; // RULE_10
         range_ext <= cfg1[`TSC_CFG1_RANGE];
         res_corr <= cfg2[`TSC_CFG2_RC];
      end
   end

   // Soft reset also aborts a running pass
   tsc_seq #(
      .TICK_CYCLES(TICK_CYCLES),
      .TICK_W(TICK_W)
   ) u_seq (
      .clock(clock),
      .rst(rst),
      .chan_on(cfg2[6:3]),
      .rate_reg(rate_reg),
      .shutdown_ctl(cfg1[`TSC_CFG1_SD]),
      .one_shot(one_shot),
      .meas_done(meas_done),
      .meas_start(meas_start),
      .meas_chan(meas_chan),
      .conv_busy(conv_busy)
   );

endmodule

// File: tsc_regs_sva.sv
// Port assertions for the sensor control block.
// Bound into tsc_regs; sees its ports only, one clock domain.
`timescale 1ns/10ps
module tsc_regs_sva (
   input wire clock,
   input wire sys_rst,
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   input wire meas_done,
   input wire meas_start,
   input wire [1:0] meas_chan,
   input wire conv_busy,
   input wire [8:0] ideality_denom,
   input wire range_ext,
   input wire res_corr
);
   // Single domain, synchronous reset
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Quiet outputs right after release
   AST_RESET_VALUES: assert property ($fell(sys_rst) |-> !sda_oe && !meas_start && !conv_busy
      && ideality_denom == 9'd300 && res_corr && !range_ext) else $error("bad value after reset");
   // Data pin is open drain only
   AST_OPEN_DRAIN: assert property (sda_out == 1'b0) else $error("data pin driven high");
   // Pull-down only moves while the bus clock is low
   AST_SDA_MOVES_LOW: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved, clock high");
   // An acknowledge or read bit stands at least a while
   AST_ACK_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*8]) else $error("pull-down too short");
   // Start pulses last one cycle
   AST_START_PULSE: assert property (meas_start |=> !meas_start) else $error("start pulse too long");
   // Pass opens with its first start
   AST_BUSY_WITH_START: assert property ($rose(conv_busy) |-> meas_start) else $error("busy without start");
   // Done leads to next channel or end of pass
   AST_DONE_NEXT: assert property (meas_done && conv_busy |=> meas_start || !conv_busy)
      else $error("no progress after done");
   // Channels climb within a pass
   AST_CHAN_ORDER: assert property (meas_start && $past(meas_done) && $past(conv_busy)
      |-> meas_chan > $past(meas_chan)) else $error("channel order broken");
   // Local channel uses the plain base
   AST_LOCAL_DENOM: assert property (conv_busy && meas_chan == 2'd0 && $past(meas_chan) == 2'd0
      |-> ideality_denom == 9'd300) else $error("local denominator wrong");
   // Signed adjust keeps the denominator in 173..428
   AST_DENOM_RANGE: assert property (ideality_denom >= 9'd173 && ideality_denom <= 9'd428)
      else $error("denominator out of range");
endmodule
bind tsc_regs tsc_regs_sva tsc_regs_sva_i (.clock(clock), .sys_rst(sys_rst), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .meas_done(meas_done), .meas_start(meas_start),
   .meas_chan(meas_chan), .conv_busy(conv_busy), .ideality_denom(ideality_denom), .range_ext(range_ext),
   .res_corr(res_corr));

// File: tsc_seq.v
// Conversion sequencer: walks enabled channels in order, then idles
// until the rate interval from the pass start is over. Assumes the front end pulses meas_done.
`timescale 1ns/10ps
`include "tsc_consts.vh"
module tsc_seq #(
   parameter TICK_CYCLES = `TSC_TICK_CYCLES,
   parameter TICK_W = 25
) (
   input wire clock,
   input wire rst,
   input wire [3:0] chan_on,
   input wire [7:0] rate_reg,
   input wire shutdown_ctl,
   input wire one_shot,
   input wire meas_done,
   output reg meas_start,
   output reg [1:0] meas_chan,
   output reg conv_busy
);

   localparam SQ_WAIT = 1'b0;
   localparam SQ_MEAS = 1'b1;

   reg state; // Waiting or measuring
   reg [TICK_W-1:0] tick_cnt; // Cycles within one eighth second
   reg [7:0] eighth_cnt; // Eighths since pass start, saturating
   reg [2:0] rate_code; // Saturated rate code
   reg [7:0] nominal; // Nominal period in eighths
   reg [7:0] n_on; // Enabled channel count
   reg [7:0] period; // Effective period in eighths
   reg first_hit; // A channel at or after search start
   reg [1:0] first_ch; // That channel
   reg [1:0] search_from; // Search start index
   integer i;

   // Period is the larger of nominal and one eighth per channel
   always @* begin
      rate_code = (|rate_reg[7:3]) ? 3'h7 : rate_reg[2:0];
      nominal = `TSC_SLOWEST_EIGHTHS >> rate_code; // RULE_01
      n_on = {4'h0, 3'h0, chan_on[0]} + {7'h0, chan_on[1]} + {7'h0, chan_on[2]} + {7'h0, chan_on[3]};
      period = (n_on > nominal) ? n_on : nominal; // RULE_02 RULE_03
   end

   // Next enabled channel at or after the search start
   always @* begin
      search_from = (state == SQ_MEAS) ? meas_chan + 2'h1 : 2'h0;
      first_hit = 1'b0;
      first_ch = 2'h0;
      for (i = 3; i >= 0; i = i - 1) begin
         if (chan_on[i] && (i[1:0] >= search_from) && !(state == SQ_MEAS && meas_chan == 2'h3)) begin
            first_hit = 1'b1; // RULE_22
            first_ch = i[1:0];
         end
      end
   end

   // Sequencer; reset starts a fresh pass from the local channel
   always @(posedge clock) begin
      if (rst) begin
         state <= SQ_WAIT; // RULE_24
         tick_cnt <= {TICK_W{1'b0}};
         eighth_cnt <= 8'hff;
         meas_start <= 1'b0;
         meas_chan <= 2'h0;
         conv_busy <= 1'b0;
      end else begin
         meas_start <= 1'b0;
         // Eighth-second time base
         if (tick_cnt == TICK_CYCLES[TICK_W-1:0] - 1'b1) begin
            tick_cnt <= {TICK_W{1'b0}};
            if (eighth_cnt != 8'hff)
               eighth_cnt <= eighth_cnt + 8'h01;
         end else begin
            tick_cnt <= tick_cnt + 1'b1;
         end
         case (state)
            SQ_WAIT: begin
               // One-shot is only seen here, so busy passes drop it
               if ((!shutdown_ctl && eighth_cnt >= period) || (shutdown_ctl && one_shot)) begin // RULE_04 RULE_07 RULE_24
                  tick_cnt <= {TICK_W{1'b0}};
                  eighth_cnt <= 8'h00;
                  if (first_hit) begin
                     state <= SQ_MEAS; // RULE_21
                     meas_chan <= first_ch;
                     meas_start <= 1'b1;
                     conv_busy <= 1'b1;
                  end
               end
            end
            default: begin
               if (meas_done) begin
                  if (first_hit) begin
                     meas_chan <= first_ch; // RULE_21
                     meas_start <= 1'b1;
                  end else begin
                     // Pass over; shutdown keeps it from restarting
                     state <= SQ_WAIT; // RULE_05
                     conv_busy <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

endmodule

// File: tsc_sync.v
// Two-stage synchroniser for levels from outside the clock domain.
// Assumes the input is a slow level such as a bus pin.
`timescale 1ns/10ps
module tsc_sync #(
   parameter WIDTH = 1
) (
   input wire clock,
   input wire sys_rst,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta; // First stage, read only by sync_out

   // Bus idles high, so both stages reset to ones
   always @(posedge clock) begin
      if (sys_rst) begin
         meta <= {WIDTH{1'b1}};
         sync_out <= {WIDTH{1'b1}};
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule
